// >>> shared/lin_mode_pkg.sv
// Constants and mode codes of the LIN transceiver mode controller
package lin_mode_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int CNT_W = 23;

    // Reset hold after the regulator is up
    localparam int RESET_TIME_MS = 4;
    localparam int RESET_CYC = (RESET_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Dominant time-out of the transmit input
    localparam int TDOM_TIME_MS = 6;
    localparam int TDOM_CYC = (TDOM_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Transmit held low this long still allows a sleep request
    localparam int SLEEP_TXD_TIME_MS = 20;
    localparam int SLEEP_TXD_CYC =
        (SLEEP_TXD_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Transmit high this long re-arms the driver
    localparam int REARM_TIME_NS = 10000;
    localparam int REARM_CYC = (REARM_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Mode-select window after the enable falling edge
    localparam int WINDOW_TIME_NS = 3200;
    localparam int WINDOW_CYC = WINDOW_TIME_NS / CLK_PERIOD_NS;
    // Least dominant time that qualifies a remote wake-up
    localparam int WAKE_TIME_US = 100;
    localparam int WAKE_CYC = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    localparam logic [11:0] REARM_CNT = 12'(REARM_CYC);
    localparam logic [9:0] WINDOW_CNT = 10'(WINDOW_CYC);

    typedef enum logic [4:0] {
        MODE_UNPOWERED = 5'h01,
        MODE_FAILSAFE = 5'h02,
        MODE_NORMAL = 5'h04,
        MODE_SILENT = 5'h08,
        MODE_SLEEP = 5'h10
    } mode_e;

endpackage

// >>> hdl/lin_mode_ctrl.sv
// LIN transceiver mode controller with wake-up, time-out and reset timing
//
// Function
// - Normal: transmit drives bus, receive follows
// - Regulator undervoltage outside sleep: reset low, go fail-safe
// - Enable fall with transmit high: silent
// - Silent: no transmit, receive high, regulator on
// - Low-power: prewake level enables receiver, termination
// - Wake-up needs long dominant, then rise
// - Wake in silent: fail-safe, receive low
// - Enable high in silent: go normal
// - Enable fall with transmit low: sleep
// - Sleep: regulator off, reset and receive low
// - Wake in sleep: fail-safe, regulator on
// - Enable high in sleep: fail-safe, then normal
// - Power-up: fail-safe, reset low 4 ms
// - Fail-safe until enable high, then normal
// - Battery loss in low power: restart fail-safe
// - External reset low forces fail-safe
// - No mode change during reset delay
// - Driver overheat: driver off, receive high
// - Bus shorted low: low power allowed, wakes once the bus is released
// - Regulator overload or overheat: fail-safe, restart
// - Open enable reads low, open transmit high
// - Transmit stuck low: sleep after 20 ms
// - Dominant time-out releases driver until re-armed
// - Normal: receive high recessive, low dominant
`timescale 1ns/1ps
`default_nettype none

module lin_mode_ctrl #(
    parameter int RESET_CYCLES = lin_mode_pkg::RESET_CYC,
    parameter int TDOM_CYCLES = lin_mode_pkg::TDOM_CYC,
    parameter int SLEEP_TXD_CYCLES = lin_mode_pkg::SLEEP_TXD_CYC,
    parameter int WAKE_CYCLES = lin_mode_pkg::WAKE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host pins
    input wire logic mode_enable,
    input wire logic mode_enable_driven,
    input wire logic transmit,
    input wire logic transmit_driven,
    output logic receive_data,
    input wire logic undervoltage_reset_n_i,
    output logic undervoltage_reset_n_o,
    output logic undervoltage_reset_n_oe,
    // Bus side
    input wire logic lin_level,
    input wire logic prewake_threshold,
    output logic lin_drive_dominant,
    output logic bus_receiver_enable,
    output logic termination_enable,
    // Supply and thermal monitors
    input wire logic supply_undervoltage_threshold,
    input wire logic regulator_undervoltage,
    input wire logic regulator_overload,
    input wire logic regulator_thermal_limit,
    input wire logic bus_driver_thermal_limit,
    output logic regulator_enable,
    // State
    output lin_mode_pkg::mode_e mode
);
    import lin_mode_pkg::*;

    localparam logic [CNT_W-1:0] RST_N = CNT_W'(RESET_CYCLES);
    localparam logic [CNT_W-1:0] TDOM_N = CNT_W'(TDOM_CYCLES);
    localparam logic [CNT_W-1:0] SLEEP_N = CNT_W'(SLEEP_TXD_CYCLES);
    localparam logic [CNT_W-1:0] WAKE_N = CNT_W'(WAKE_CYCLES);

    typedef struct packed {
        mode_e mode;
        logic en_s1;
        logic en_s2;
        logic en_prev;
        logic txd_s1;
        logic txd_s2;
        logic lin_q;
        logic [CNT_W-1:0] rst_cnt;
        logic [CNT_W-1:0] dom_cnt;
        logic [11:0] rearm_cnt;
        logic sel_busy;
        logic [9:0] sel_cnt;
        logic sel_txd_low;
        logic [CNT_W-1:0] wake_cnt;
        logic drv_off;
        logic wake_flag;
        logic rxd;
        logic lin_dom;
        logic undervoltage_reset_n_low;
    } state_s;

    localparam state_s STATE_RST = '{
        mode: MODE_UNPOWERED,
        en_s1: 1'b0, en_s2: 1'b0, en_prev: 1'b0,
        txd_s1: 1'b1, txd_s2: 1'b1, lin_q: 1'b1,
        rst_cnt: '0, dom_cnt: '0, rearm_cnt: '0,
        sel_busy: 1'b0, sel_cnt: '0, sel_txd_low: 1'b0,
        wake_cnt: '0, drv_off: 1'b0, wake_flag: 1'b0,
        rxd: 1'b0, lin_dom: 1'b0, undervoltage_reset_n_low: 1'b1
    };

    state_s s_q;
    state_s s_d;

    logic en_pin;
    logic txd_pin;
    logic en_fall;
    logic low_power;
    logic listening;
    logic wake_hit;
    logic ext_reset;
    logic reg_fault;
    logic sleep_ok;

    // Pull-down on enable, pull-up on transmit when not driven
    assign en_pin = mode_enable_driven & mode_enable;
    assign txd_pin = ~transmit_driven | transmit;

    assign en_fall = s_q.en_prev & ~s_q.en_s2;
    assign low_power = (s_q.mode == MODE_SILENT) || (s_q.mode == MODE_SLEEP);
    assign listening = low_power & prewake_threshold;
    // Rising bus edge after a qualified dominant phase
    assign wake_hit = low_power & s_q.lin_q & (s_q.wake_cnt == WAKE_N);
    // Only a pull-down from outside counts, not our own drive
    assign ext_reset = ~undervoltage_reset_n_i & ~s_q.undervoltage_reset_n_low;
    assign reg_fault = regulator_overload | regulator_thermal_limit;
    // Stuck-low transmit may still request sleep once 20 ms have passed
    assign sleep_ok = ~s_q.drv_off || (s_q.dom_cnt == SLEEP_N);

    always_comb begin
        s_d = s_q;
        s_d.en_s1 = en_pin;
        s_d.en_s2 = s_q.en_s1;
        s_d.en_prev = s_q.en_s2;
        s_d.txd_s1 = txd_pin;
        s_d.txd_s2 = s_q.txd_s1;
        s_d.lin_q = lin_level;

        // Dominant time-out and re-arm timers
        if (s_q.txd_s2) begin
            s_d.dom_cnt = '0;
        end else if (s_q.dom_cnt != SLEEP_N) begin
            s_d.dom_cnt = s_q.dom_cnt + 1'b1;
        end
        if (!s_q.txd_s2) begin
            s_d.rearm_cnt = '0;
        end else if (s_q.rearm_cnt != REARM_CNT) begin
            s_d.rearm_cnt = s_q.rearm_cnt + 1'b1;
        end
        if (!s_q.txd_s2 && s_q.dom_cnt >= TDOM_N) begin
            s_d.drv_off = 1'b1;
        end else if (s_q.rearm_cnt == REARM_CNT) begin
            s_d.drv_off = 1'b0;
        end

        // Reset delay runs only once the regulator is up
        if (s_q.rst_cnt != '0 && !regulator_undervoltage) begin
            s_d.rst_cnt = s_q.rst_cnt - 1'b1;
        end

        // Dominant duration while the wake receiver listens; the count is
        // held through the rising edge, since the prewake level drops first
        if (!low_power || s_q.lin_q) begin
            s_d.wake_cnt = '0;
        end else if (listening && s_q.wake_cnt != WAKE_N) begin
            s_d.wake_cnt = s_q.wake_cnt + 1'b1;
        end

        // Mode-select window
        if (s_q.sel_busy) begin
            s_d.sel_cnt = s_q.sel_cnt + 1'b1;
        end

        if (!supply_undervoltage_threshold) begin
            // Battery lost: come back through fail-safe
            s_d.mode = MODE_UNPOWERED;
            s_d.rst_cnt = RST_N;
            s_d.wake_flag = 1'b0;
            s_d.sel_busy = 1'b0;
        end else if (s_q.mode != MODE_UNPOWERED && (ext_reset || reg_fault ||
                (regulator_undervoltage && s_q.mode != MODE_SLEEP))) begin
            s_d.mode = MODE_FAILSAFE;
            s_d.sel_busy = 1'b0;
            if (regulator_undervoltage || reg_fault) begin
                s_d.rst_cnt = RST_N;
            end
        end else begin
            unique case (s_q.mode)
                MODE_UNPOWERED: begin
                    s_d.mode = MODE_FAILSAFE;
                    s_d.rst_cnt = RST_N;
                end
                MODE_FAILSAFE: begin
                    if (s_q.en_s2 && s_q.rst_cnt == '0) begin
                        s_d.mode = MODE_NORMAL;
                        s_d.wake_flag = 1'b0;
                    end
                end
                MODE_NORMAL: begin
                    if (en_fall) begin
                        s_d.sel_busy = 1'b1;
                        s_d.sel_cnt = '0;
                        s_d.sel_txd_low = ~s_q.txd_s2;
                    end else if (s_q.sel_busy &&
                            s_q.sel_cnt == WINDOW_CNT) begin
                        s_d.sel_busy = 1'b0;
                        if ((s_q.sel_txd_low || !s_q.txd_s2) && sleep_ok) begin
                            s_d.mode = MODE_SLEEP;
                        end else begin
                            s_d.mode = MODE_SILENT;
                        end
                    end
                end
                MODE_SILENT: begin
                    if (wake_hit) begin
                        s_d.mode = MODE_FAILSAFE;
                        s_d.wake_flag = 1'b1;
                    end else if (s_q.en_s2) begin
                        s_d.mode = MODE_NORMAL;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_hit || s_q.en_s2) begin
                        s_d.mode = MODE_FAILSAFE;
                        s_d.wake_flag = wake_hit;
                        s_d.rst_cnt = RST_N;
                    end
                end
            endcase
        end

        // Pin outputs follow the next mode
        s_d.undervoltage_reset_n_low = (s_d.rst_cnt != '0) || (s_d.mode == MODE_SLEEP) ||
            (s_d.mode == MODE_UNPOWERED);
        s_d.lin_dom = (s_d.mode == MODE_NORMAL) && !s_d.sel_busy &&
            !s_q.txd_s2 && !s_d.drv_off && !bus_driver_thermal_limit;
        unique case (s_d.mode)
            MODE_NORMAL: begin
                s_d.rxd = s_q.lin_q | bus_driver_thermal_limit;
            end
            MODE_FAILSAFE: s_d.rxd = ~s_d.wake_flag;
            MODE_SILENT: s_d.rxd = 1'b1;
            default: s_d.rxd = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign mode = s_q.mode;
    assign receive_data = s_q.rxd;
    assign lin_drive_dominant = s_q.lin_dom;
    assign undervoltage_reset_n_o = 1'b0;
    assign undervoltage_reset_n_oe = s_q.undervoltage_reset_n_low;
    assign bus_receiver_enable = ~low_power | prewake_threshold;
    assign termination_enable = ~low_power | prewake_threshold;
    assign regulator_enable = (s_q.mode != MODE_SLEEP) &&
        (s_q.mode != MODE_UNPOWERED) && !regulator_thermal_limit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_normal_fall_high;
        (s_q.mode == MODE_NORMAL) && en_fall && s_q.txd_s2;
    endsequence

    sequence seq_window_high;
        s_q.txd_s2 && supply_undervoltage_threshold && !ext_reset &&
            !reg_fault && !regulator_undervoltage;
    endsequence

    a_silent_entry: assert property (
        seq_normal_fall_high ##1 seq_window_high [*8] |->
            ##[0:700] s_q.mode == MODE_SILENT)
        else $error("silent mode not reached after enable fall");

    a_sleep_outputs: assert property (
        s_q.mode == MODE_SLEEP |-> !receive_data && undervoltage_reset_n_oe
            && !regulator_enable && !lin_drive_dominant)
        else $error("sleep outputs wrong");

    a_silent_outputs: assert property (
        $past(s_q.mode) == MODE_SILENT && s_q.mode == MODE_SILENT |->
            receive_data && !lin_drive_dominant)
        else $error("silent outputs wrong");

    a_uv_failsafe: assert property (
        (s_q.mode == MODE_NORMAL || s_q.mode == MODE_SILENT) &&
            regulator_undervoltage && supply_undervoltage_threshold |=>
            s_q.mode == MODE_FAILSAFE && undervoltage_reset_n_oe)
        else $error("undervoltage did not force fail-safe");

    a_wake_rxd_low: assert property (
        s_q.mode == MODE_SILENT && wake_hit && supply_undervoltage_threshold
            && !ext_reset && !reg_fault && !regulator_undervoltage |=>
            s_q.mode == MODE_FAILSAFE && !receive_data)
        else $error("wake-up not reported");

    a_timeout_release: assert property (
        s_q.drv_off |-> !lin_drive_dominant)
        else $error("driver active after dominant time-out");

    a_reset_hold: assert property (
        s_q.rst_cnt != '0 && s_q.mode == MODE_FAILSAFE |->
            undervoltage_reset_n_oe ##1 s_q.mode != MODE_NORMAL)
        else $error("mode changed during reset delay");

    a_ext_reset: assert property (
        ext_reset && supply_undervoltage_threshold &&
            s_q.mode != MODE_UNPOWERED |=> s_q.mode == MODE_FAILSAFE)
        else $error("external reset ignored");

    a_normal_rx: assert property (
        $past(s_q.mode) == MODE_NORMAL && s_q.mode == MODE_NORMAL &&
            !$past(bus_driver_thermal_limit) |->
            receive_data == $past(s_q.lin_q))
        else $error("receive does not follow bus");

    a_fail_to_normal: assert property (
        s_q.mode == MODE_FAILSAFE && s_q.en_s2 && s_q.rst_cnt == '0 &&
            supply_undervoltage_threshold && !ext_reset && !reg_fault &&
            !regulator_undervoltage |=> s_q.mode == MODE_NORMAL)
        else $error("fail-safe did not go normal");

    a_wake_sleep: assert property (
        s_q.mode == MODE_SLEEP && wake_hit && supply_undervoltage_threshold
            && !ext_reset && !reg_fault |=>
            s_q.mode == MODE_FAILSAFE && !receive_data &&
            (regulator_enable || regulator_thermal_limit))
        else $error("wake-up from sleep not reported");

    a_sleep_enable: assert property (
        s_q.mode == MODE_SLEEP && s_q.en_s2 && supply_undervoltage_threshold
            |=> s_q.mode == MODE_FAILSAFE && undervoltage_reset_n_oe)
        else $error("enable high did not leave sleep");

endmodule // lin_mode_ctrl

`default_nettype wire

// >>> tb/lin_host_model.sv
// Host and bus model facing the LIN transceiver mode controller
`timescale 1ns/1ps
`default_nettype none

module lin_host_model (
    // Host commands from the bench
    input wire logic en_cmd,
    input wire logic tx_cmd,
    input wire logic host_rst,
    input wire logic remote_dom,
    // Device outputs
    input wire logic lin_dom,
    input wire logic rst_o,
    input wire logic rst_oe,
    // Pin levels seen by the device
    output logic mode_enable,
    output logic transmit,
    output logic lin_level,
    output logic prewake,
    output logic rst_wire
);
    // Host holds both pins steady through the mode-select window
    assign mode_enable = en_cmd;
    assign transmit = tx_cmd;
    // Wired-and bus with pull-up; a remote node may pull it dominant
    assign lin_level = ~(lin_dom | remote_dom);
    assign prewake = ~lin_level;
    // Open-drain reset wire with pull-up, either side may pull it low
    assign rst_wire = ~((rst_oe & ~rst_o) | host_rst);
endmodule // lin_host_model

`default_nettype wire

// >>> tb/lin_mode_ctrl_tb.sv
// Self-checking testbench of the LIN transceiver mode controller
`timescale 1ns/1ps
`default_nettype none

module lin_mode_ctrl_tb;
    import lin_mode_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_cmd = 1'b0;
    logic tx_cmd = 1'b1;
    logic host_rst = 1'b0;
    logic remote_dom = 1'b0;
    logic en_drv = 1'b1;
    logic tx_drv = 1'b1;
    logic supply_ok = 1'b1;
    logic reg_uv = 1'b0;
    logic reg_ovl = 1'b0;
    logic reg_hot = 1'b0;
    logic drv_hot = 1'b0;
    logic mode_enable, transmit, lin_level, prewake, rst_wire;
    logic receive_data, rst_o, rst_oe, lin_dom, rx_en, reg_en, term_en;
    mode_e mode;
    int miscompares = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    lin_host_model host (.en_cmd(en_cmd), .tx_cmd(tx_cmd),
        .host_rst(host_rst), .remote_dom(remote_dom), .lin_dom(lin_dom),
        .rst_o(rst_o), .rst_oe(rst_oe), .mode_enable(mode_enable),
        .transmit(transmit), .lin_level(lin_level), .prewake(prewake),
        .rst_wire(rst_wire));

    lin_mode_ctrl #(.RESET_CYCLES(50), .TDOM_CYCLES(40),
        .SLEEP_TXD_CYCLES(80), .WAKE_CYCLES(20)) dut (.clk(clk),
        .rst_n(rst_n), .mode_enable(mode_enable),
        .mode_enable_driven(en_drv), .transmit(transmit),
        .transmit_driven(tx_drv), .receive_data(receive_data),
        .undervoltage_reset_n_i(rst_wire), .undervoltage_reset_n_o(rst_o),
        .undervoltage_reset_n_oe(rst_oe), .lin_level(lin_level),
        .prewake_threshold(prewake), .lin_drive_dominant(lin_dom),
        .bus_receiver_enable(rx_en), .termination_enable(term_en),
        .supply_undervoltage_threshold(supply_ok),
        .regulator_undervoltage(reg_uv), .regulator_overload(reg_ovl),
        .regulator_thermal_limit(reg_hot),
        .bus_driver_thermal_limit(drv_hot), .regulator_enable(reg_en),
        .mode(mode));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic check_mode(input mode_e got, input mode_e exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // Bounded wait; a miss is a mismatch and ends the run
    task automatic wait_mode(input mode_e exp, input int lim);
        int i;
        for (i = 0; i < lim && mode !== exp; i++)
            tick(1);
        check_mode(mode, exp);
        if (mode !== exp)
            conclude();
    endtask

    task automatic t_power_up();
        tick(2);
        check_mode(mode, MODE_FAILSAFE);
        check_bit(reg_en, 1'b1);
        check_bit(rst_wire, 1'b0);
        en_cmd = 1'b1;
        tick(20);
        check_mode(mode, MODE_FAILSAFE);
        wait_mode(MODE_NORMAL, 60);
        check_bit(rst_wire, 1'b1);
    endtask

    task automatic t_normal();
        tx_cmd = 1'b0;
        tick(3);
        check_bit(lin_dom, 1'b1);
        tick(3);
        check_bit(receive_data, 1'b0);
        check_bit(reg_en, 1'b1);
        tx_cmd = 1'b1;
        tick(6);
        check_bit(lin_dom, 1'b0);
        check_bit(receive_data, 1'b1);
    endtask

    task automatic t_faults();
        reg_uv = 1'b1;
        tick(2);
        check_mode(mode, MODE_FAILSAFE);
        check_bit(rst_wire, 1'b0);
        reg_uv = 1'b0;
        wait_mode(MODE_NORMAL, 70);
        host_rst = 1'b1;
        tick(2);
        check_mode(mode, MODE_FAILSAFE);
        host_rst = 1'b0;
        wait_mode(MODE_NORMAL, 70);
        reg_ovl = 1'b1;
        tick(2);
        check_mode(mode, MODE_FAILSAFE);
        reg_hot = 1'b1;
        tick(2);
        check_bit(reg_en, 1'b0);
        en_cmd = 1'b0;
        reg_ovl = 1'b0;
        reg_hot = 1'b0;
        tick(4);
        check_bit(reg_en, 1'b1);
        check_mode(mode, MODE_FAILSAFE);
        en_cmd = 1'b1;
        wait_mode(MODE_NORMAL, 70);
        tx_cmd = 1'b0;
        drv_hot = 1'b1;
        tick(4);
        check_bit(lin_dom, 1'b0);
        check_bit(receive_data, 1'b1);
        check_bit(reg_en, 1'b1);
        drv_hot = 1'b0;
        tick(4);
        check_bit(lin_dom, 1'b1);
        tx_cmd = 1'b1;
        tick(4);
    endtask

    task automatic t_rearm();
        tx_cmd = 1'b0;
        tick(30);
        check_bit(lin_dom, 1'b1);
        tick(20);
        check_bit(lin_dom, 1'b0);
        tx_cmd = 1'b1;
        tick(100);
        tx_cmd = 1'b0;
        tick(4);
        check_bit(lin_dom, 1'b0);
        tx_cmd = 1'b1;
        tick(REARM_CYC + 10);
        tx_cmd = 1'b0;
        tick(4);
        check_bit(lin_dom, 1'b1);
        tx_cmd = 1'b1;
        tick(4);
    endtask

    task automatic t_silent_wake();
        en_cmd = 1'b0;
        tick(600);
        check_mode(mode, MODE_NORMAL);
        wait_mode(MODE_SILENT, 100);
        check_bit(receive_data, 1'b1);
        check_bit(reg_en, 1'b1);
        check_bit(rx_en, 1'b0);
        check_bit(term_en, 1'b0);
        remote_dom = 1'b1;
        tick(5);
        check_bit(rx_en, 1'b1);
        check_bit(term_en, 1'b1);
        check_bit(lin_dom, 1'b0);
        remote_dom = 1'b0;
        tick(5);
        check_mode(mode, MODE_SILENT);
        remote_dom = 1'b1;
        tick(30);
        remote_dom = 1'b0;
        tick(3);
        check_mode(mode, MODE_FAILSAFE);
        check_bit(receive_data, 1'b0);
        en_cmd = 1'b1;
        wait_mode(MODE_NORMAL, 10);
    endtask

    task automatic t_open_pins();
        tx_drv = 1'b0;
        tx_cmd = 1'b0;
        tick(4);
        check_bit(lin_dom, 1'b0);
        en_drv = 1'b0;
        wait_mode(MODE_SILENT, 700);
        en_drv = 1'b1;
        tick(4);
        check_mode(mode, MODE_NORMAL);
        tx_drv = 1'b1;
        tx_cmd = 1'b1;
    endtask

    task automatic t_sleep_short();
        remote_dom = 1'b1;
        tx_cmd = 1'b0;
        en_cmd = 1'b0;
        tick(4);
        check_bit(lin_dom, 1'b0);
        wait_mode(MODE_SLEEP, 700);
        check_bit(reg_en, 1'b0);
        check_bit(receive_data, 1'b0);
        check_bit(rst_wire, 1'b0);
        tx_cmd = 1'b1;
        tick(40);
        check_mode(mode, MODE_SLEEP);
        remote_dom = 1'b0;
        tick(3);
        check_mode(mode, MODE_FAILSAFE);
        check_bit(reg_en, 1'b1);
        check_bit(receive_data, 1'b0);
        en_cmd = 1'b1;
        wait_mode(MODE_NORMAL, 80);
    endtask

    task automatic t_sleep_enable();
        tx_cmd = 1'b0;
        tick(90);
        check_bit(lin_dom, 1'b0);
        en_cmd = 1'b0;
        wait_mode(MODE_SLEEP, 700);
        tx_cmd = 1'b1;
        supply_ok = 1'b0;
        tick(2);
        check_mode(mode, MODE_UNPOWERED);
        supply_ok = 1'b1;
        tick(2);
        check_mode(mode, MODE_FAILSAFE);
        tick(10);
        check_mode(mode, MODE_FAILSAFE);
        check_bit(rst_wire, 1'b0);
        en_cmd = 1'b1;
        wait_mode(MODE_NORMAL, 70);
        en_cmd = 1'b0;
        tx_cmd = 1'b0;
        wait_mode(MODE_SLEEP, 700);
        tx_cmd = 1'b1;
        en_cmd = 1'b1;
        tick(4);
        check_mode(mode, MODE_FAILSAFE);
        wait_mode(MODE_NORMAL, 70);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_power_up();
        t_normal();
        t_faults();
        t_rearm();
        t_silent_wake();
        t_open_pins();
        t_sleep_short();
        t_sleep_enable();
        conclude();
    end
endmodule // lin_mode_ctrl_tb

`default_nettype wire
